/* File: hdl/c16i_core.sv */
// Purpose: 16-bit two-stage pipelined CPU core with dual-mode PC and flags
// Assumes: Memory read is combinational from mem_addr; writes at the clock edge
// Notes:   Interrupt request and vector come from logic on the same clock
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module c16i_core
  import c16i_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                reset_n,
  input  wire c16i_apb_req_t       apb_req,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  output logic [C16I_DW-1:0]       mem_addr,
  output logic                     mem_we,
  output logic [C16I_DW-1:0]       mem_wdata,
  input  wire logic [C16I_DW-1:0]  mem_rdata,
  input  wire logic                irq_req,
  input  wire logic [C16I_DW-1:0]  irq_vector,
  output logic                     interrupt_entry_pulse,
  output logic                     irq_mode,
  output logic                     illegal_op
);

  c16i_state_t        s_q;
  c16i_state_t        s_d;

  logic [4:0]         op;
  logic [2:0]         dest_field;
  logic [2:0]         first_source_field;
  logic [2:0]         second_source_field;
  logic               imm_sel;
  logic [3:0]         nib;
  logic [15:0]        opa;
  logic [15:0]        opb;
  logic [15:0]        add_b;
  logic               add_cin;
  logic               sub_sel;
  logic [16:0]        sum;
  logic [15:0]        pc_cur;
  logic [15:0]        pc_inc;
  logic [15:0]        br_target;
  logic [15:0]        jump_target;
  logic [3:0]         flags_cur;
  logic [3:0]         flags_new;
  logic [15:0]        wb_data;
  logic               wb_en;
  logic               cond_true;
  logic               jump_taken;
  logic               interrupt_return_exec;
  logic               mem_exec;
  logic               inline_exec;
  logic               store_exec;
  logic               logic_exec;
  logic               simple;
  logic               take_irq;
  logic               in_memop;
  logic               in_store;
  logic [15:0]        fwd_a;
  logic [15:0]        fwd_b;
  logic               apb_access;

  assign pready                = s_q.pready;
  assign prdata                = s_q.prdata;
  assign pslverr               = s_q.pslverr;
  assign mem_addr              = s_q.mem_addr;
  assign mem_we                = s_q.mem_we;
  assign mem_wdata             = s_q.mem_wdata;
  assign interrupt_entry_pulse = s_q.entry;
  assign irq_mode              = s_q.mode;
  assign illegal_op            = s_q.illegal;

  //////////////////////////////////////////////////////////////////////////////
  // Execute stage decode and ALU

  always_comb begin
    op                  = s_q.instr_reg[15:11];
    dest_field          = s_q.instr_reg[10:8];
    imm_sel             = s_q.instr_reg[7];
    first_source_field  = s_q.instr_reg[6:4];
    second_source_field = s_q.instr_reg[2:0];
    nib                 = s_q.instr_reg[3:0];
    flags_cur           = s_q.flags[s_q.mode];
    pc_cur              = s_q.pc[s_q.mode];
    pc_inc              = pc_cur + 16'h0001;
    opa                 = s_q.bank[first_source_field];
    opb                 = imm_sel ? {12'h000, nib} : s_q.bank[second_source_field];
    sub_sel             = (op == C16I_OP_SUB) || (op == C16I_OP_DIFF_BORROW) ||
                          (op == C16I_OP_COMPARE_ONLY);
    add_b               = sub_sel ? ~opb : opb;
    add_cin             = ((op == C16I_OP_ADD_CARRY) || (op == C16I_OP_DIFF_BORROW)) ?
                          flags_cur[C16I_FLAG_C] : sub_sel;
    sum                 = {1'b0, opa} + {1'b0, add_b} + {16'h0000, add_cin};
    br_target           = pc_cur + {{4{s_q.instr_reg[11]}}, s_q.instr_reg[11:0]};
    jump_target         = br_target;
    flags_new           = flags_cur;
    wb_data             = 16'h0000;
    wb_en               = 1'b0;
    cond_true           = 1'b0;
    jump_taken          = 1'b0;
    interrupt_return_exec           = 1'b0;
    mem_exec            = 1'b0;
    inline_exec         = 1'b0;
    store_exec          = 1'b0;
    logic_exec          = 1'b0;
    if (s_q.instr_valid) begin
      if (op[4]) begin
        unique case (s_q.instr_reg[14:12])
          C16I_BR_ZERO:     cond_true = flags_cur[C16I_FLAG_Z];
          C16I_BR_NONZERO:  cond_true = !flags_cur[C16I_FLAG_Z];
          C16I_BR_CARRY:    cond_true = flags_cur[C16I_FLAG_C];
          C16I_BR_NOCARRY:  cond_true = !flags_cur[C16I_FLAG_C];
          C16I_BR_NEGATIVE: cond_true = flags_cur[C16I_FLAG_N];
          C16I_BR_POSITIVE: cond_true = !flags_cur[C16I_FLAG_N];
          C16I_BR_OVERFLOW: cond_true = flags_cur[C16I_FLAG_V];
          C16I_BR_ALWAYS:   cond_true = 1'b1;
        endcase
        jump_taken = cond_true;
      end else begin
        unique case (op)
          C16I_OP_ADD, C16I_OP_ADD_CARRY, C16I_OP_SUB, C16I_OP_DIFF_BORROW,
          C16I_OP_COMPARE_ONLY: begin
            wb_en                  = (op != C16I_OP_COMPARE_ONLY);
            wb_data                = sum[15:0];
            flags_new[C16I_FLAG_C] = sum[16];
            flags_new[C16I_FLAG_V] = (opa[15] == add_b[15]) && (sum[15] != opa[15]);
            flags_new[C16I_FLAG_N] = sum[15];
            flags_new[C16I_FLAG_Z] = (sum[15:0] == 16'h0000);
          end
          C16I_OP_AND, C16I_OP_TEST_CONJ, C16I_OP_OR, C16I_OP_XOR, C16I_OP_INVERT: begin
            logic_exec = 1'b1;
            wb_en      = (op != C16I_OP_TEST_CONJ);
            unique case (op)
              C16I_OP_AND, C16I_OP_TEST_CONJ: wb_data = opa & opb;
              C16I_OP_OR:                     wb_data = opa | opb;
              C16I_OP_XOR:                    wb_data = opa ^ opb;
              C16I_OP_INVERT: wb_data = imm_sel ? (16'h0000 - s_q.bank[second_source_field]) :
                                                  ~s_q.bank[second_source_field];
            endcase
            flags_new[C16I_FLAG_N] = wb_data[15];
            flags_new[C16I_FLAG_Z] = (wb_data == 16'h0000);
          end
          C16I_OP_SHIFT, C16I_OP_ROTATE: begin
            if (op == C16I_OP_ROTATE && imm_sel) begin
              wb_en = 1'b0;
            end else begin
              wb_en = 1'b1;
              if (op == C16I_OP_ROTATE) begin
                wb_data = {flags_cur[C16I_FLAG_C], s_q.bank[second_source_field][15:1]};
              end else if (imm_sel) begin
                wb_data = {s_q.bank[second_source_field][15], s_q.bank[second_source_field][15:1]};
              end else begin
                wb_data = {1'b0, s_q.bank[second_source_field][15:1]};
              end
              flags_new[C16I_FLAG_C] = s_q.bank[second_source_field][0];
              flags_new[C16I_FLAG_N] = wb_data[15];
              flags_new[C16I_FLAG_Z] = (wb_data == 16'h0000);
            end
          end
          C16I_OP_MEMORY: begin
            mem_exec   = 1'b1;
            store_exec = imm_sel;
            wb_en      = !imm_sel;
            wb_data    = mem_rdata;
            if (!imm_sel) begin
              flags_new[C16I_FLAG_N] = mem_rdata[15];
              flags_new[C16I_FLAG_Z] = (mem_rdata == 16'h0000);
            end
          end
          C16I_OP_JUMP_GROUP: begin
            if (!imm_sel) begin
              wb_en   = 1'b1;
              wb_data = pc_cur + {12'h000, nib};
            end else begin
              jump_taken  = 1'b1;
              interrupt_return_exec   = nib[3];
              jump_target = s_q.bank[second_source_field];
            end
          end
          C16I_OP_INLINE_FETCH: begin
            mem_exec    = 1'b1;
            inline_exec = 1'b1;
            wb_en       = 1'b1;
            wb_data     = mem_rdata;
          end
          C16I_OP_BYTE_IMM: begin
            wb_en   = 1'b1;
            wb_data = {8'h00, s_q.instr_reg[7:0]};
          end
          default: wb_en = 1'b0;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pipeline control and next state

  // Bank forwarding lets a memory op right after a write use the new value
  assign in_memop   = (mem_rdata[15:11] == C16I_OP_MEMORY);
  assign in_store   = in_memop && mem_rdata[7];
  assign fwd_a      = (wb_en && dest_field == mem_rdata[6:4]) ? wb_data : s_q.bank[mem_rdata[6:4]];
  assign fwd_b      = (wb_en && dest_field == mem_rdata[2:0]) ? wb_data : s_q.bank[mem_rdata[2:0]];
  assign simple     = !mem_exec && !jump_taken && !s_q.entry;
  assign take_irq   = irq_req && !s_q.mode && simple;
  assign apb_access = apb_req.psel && apb_req.penable;

  always_comb begin
    s_d         = s_q;
    s_d.entry   = 1'b0;
    s_d.illegal = 1'b0;
    s_d.mem_we  = 1'b0;
    s_d.pready  = 1'b0;
    s_d.pslverr = 1'b0;
    // One wait state; the write takes effect when pready is seen high
    if (apb_access && !s_q.pready) begin
      s_d.pready = 1'b1;
      s_d.prdata = 32'h0000_0000;
      if (apb_req.paddr == C16I_CTRL_OFS) begin
        s_d.prdata[C16I_CTRL_RUN] = s_q.run;
      end else if (apb_req.paddr == C16I_STATUS_OFS) begin
        s_d.prdata[15:0]           = pc_cur;
        s_d.prdata[C16I_STAT_MODE] = s_q.mode;
        s_d.prdata[C16I_STAT_RUN]  = s_q.run;
      end else begin
        s_d.pslverr = 1'b1;
      end
    end
    if (apb_access && s_q.pready && apb_req.pwrite && apb_req.paddr == C16I_CTRL_OFS) begin
      s_d.run = apb_req.pwdata[C16I_CTRL_RUN];
    end
    // Halting freezes the core; a write already issued is not repeated
    // Halting during the entry pulse drops the pulse and keeps normal mode;
    // the fetch address still holds the discarded opcode, so the request
    // is simply taken again once the core runs, with nothing lost
    if (s_q.run) begin
      s_d.illegal = s_q.instr_valid && op == C16I_OP_ROTATE && imm_sel;
      if (wb_en) begin
        s_d.bank[dest_field] = wb_data;
      end
      s_d.flags[s_q.mode] = flags_new;
      if (!s_q.mode && !s_q.entry) begin
        s_d.pc[1] = irq_vector;
      end
      if (s_q.entry) begin
        s_d.mode        = 1'b1;
        s_d.instr_valid = 1'b0;
        s_d.mem_addr    = s_q.pc[1];
      end else if (jump_taken) begin
        s_d.instr_valid = 1'b0;
        if (interrupt_return_exec && s_q.mode && irq_req) begin
          s_d.pc[1]    = irq_vector;
          s_d.mem_addr = irq_vector;
        end else if (interrupt_return_exec) begin
          s_d.mode     = 1'b0;
          s_d.mem_addr = s_q.pc[0];
        end else begin
          s_d.pc[s_q.mode] = jump_target;
          s_d.mem_addr     = jump_target;
        end
      end else if (mem_exec) begin
        s_d.instr_valid = 1'b0;
        if (inline_exec) begin
          s_d.pc[s_q.mode] = pc_inc;
          s_d.mem_addr     = pc_inc;
        end else begin
          s_d.mem_addr = pc_cur;
        end
      end else if (take_irq) begin
        s_d.entry       = 1'b1;
        s_d.instr_valid = 1'b0;
        s_d.mem_addr    = pc_cur;
      end else begin
        s_d.instr_reg    = mem_rdata;
        s_d.instr_valid  = 1'b1;
        s_d.pc[s_q.mode] = pc_inc;
        s_d.mem_addr     = pc_inc;
        if (in_memop) begin
          s_d.mem_addr  = fwd_a;
          s_d.mem_we    = in_store;
          s_d.mem_wdata = fwd_b;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= C16I_STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_entry_step;
    s_q.entry && !s_q.mode && s_q.run;
  endsequence

  sequence s_vector_fetch;
    s_q.mode && !s_q.instr_valid && !s_q.entry;
  endsequence

  property p_entry_order;
    s_entry_step |=> s_vector_fetch;
  endproperty

  a_entry_pulse_width: assert property (s_q.entry |=> !s_q.entry)
    else $error("entry pulse longer than one cycle");
  a_entry_mode_order: assert property (p_entry_order)
    else $error("mode did not follow entry pulse");
  a_entry_vector_addr: assert property (s_entry_step |=> s_q.mem_addr == $past(s_q.pc[1]))
    else $error("vector not presented after entry");
  a_no_nested_entry: assert property (s_q.mode |=> !s_q.entry)
    else $error("entry while in interrupt mode");
  a_mem_slot_bubble: assert property (mem_exec && s_q.run |=> !s_q.instr_valid)
    else $error("opcode not discarded after memory op");
  a_jump_redirect: assert property (jump_taken && !interrupt_return_exec && s_q.run |=>
                                    s_q.mem_addr == $past(jump_target) && !s_q.instr_valid)
    else $error("taken jump did not redirect fetch");
  a_seq_throughput: assert property (s_q.run && simple && !take_irq |=>
                                     s_q.instr_valid && s_q.pc[s_q.mode] == $past(pc_inc))
    else $error("sequential fetch stalled");
  a_logic_keeps_cv: assert property (logic_exec && s_q.run |=>
                                     s_q.flags[s_q.mode][C16I_FLAG_C] == $past(flags_cur[C16I_FLAG_C]) &&
                                     s_q.flags[s_q.mode][C16I_FLAG_V] == $past(flags_cur[C16I_FLAG_V]))
    else $error("logic op changed carry or overflow");
  a_chain_stays: assert property (interrupt_return_exec && s_q.mode && irq_req && s_q.run |=>
                                  s_q.mode && s_q.mem_addr == $past(irq_vector))
    else $error("return with pending request did not chain");
  a_return_normal: assert property (interrupt_return_exec && s_q.mode && !irq_req && s_q.run |=>
                                    !s_q.mode && s_q.mem_addr == $past(s_q.pc[0]))
    else $error("return did not resume normal program");
  a_store_issue: assert property (store_exec && $past(s_q.run) |-> s_q.mem_we)
    else $error("store executed without write strobe");

  // Datapath checks; each looks one cycle after the executing opcode
  a_shift_carry_out: assert property (s_q.run && s_q.instr_valid && (op == C16I_OP_SHIFT ||
                                      (op == C16I_OP_ROTATE && !imm_sel)) |=>
                                      s_q.flags[s_q.mode][C16I_FLAG_C] == $past(s_q.bank[second_source_field][0]))
    else $error("shift did not move bit zero into carry");
  a_byte_imm_flags: assert property (s_q.run && s_q.instr_valid && op == C16I_OP_BYTE_IMM |=>
                                     s_q.flags[s_q.mode] == $past(flags_cur))
    else $error("byte immediate load changed flags");
  a_store_keeps_flags: assert property (store_exec && s_q.run |=> s_q.flags[s_q.mode] == $past(flags_cur))
    else $error("memory write changed flags");
  a_load_zero_flag: assert property (mem_exec && !store_exec && !inline_exec && s_q.run |=>
                                     s_q.flags[s_q.mode][C16I_FLAG_Z] == ($past(mem_rdata) == 16'h0000))
    else $error("memory load zero flag wrong");
  a_relative_add_pc: assert property (s_q.run && s_q.instr_valid && op == C16I_OP_JUMP_GROUP && !imm_sel |=>
                                      s_q.bank[$past(dest_field)] == $past(s_q.mem_addr) + {12'h000, $past(nib)})
    else $error("relative add did not use the next address");
  a_branch_falls_thru: assert property (s_q.run && s_q.instr_valid && op[4] && !cond_true && !take_irq |=>
                                        s_q.instr_valid)
    else $error("untaken branch discarded the next opcode");
  a_illegal_no_effect: assert property (s_q.run && s_q.instr_valid && op == C16I_OP_ROTATE && imm_sel |=>
                                        s_q.bank == $past(s_q.bank) && s_q.flags[s_q.mode] == $past(flags_cur))
    else $error("reserved encoding changed state");
  a_vector_precharge: assert property (s_q.run && !s_q.mode && !s_q.entry |=>
                                       s_q.pc[1] == $past(irq_vector))
    else $error("interrupt counter not precharged with vector");
  a_inline_advance: assert property (inline_exec && s_q.run |=>
                                     s_q.mem_addr == $past(pc_inc) && !s_q.instr_valid)
    else $error("inline word fetch did not skip the data word");

endmodule // c16i_core
`default_nettype wire

/* File: hdl/c16i_pkg.sv */
// Purpose: Shared constants and types of the 16-bit dual-mode CPU core
// Assumes: One clock, async active-low reset, APB register access
// Notes:   Summary of operation follows
// Summary of operation
// - Fetch and execute overlap, one per cycle
// - Memory ops use port, next opcode discarded
// - Taken jump discards fetched opcode, refetches
// - Flags carry, zero, negative, overflow; branches test one
// - ALU add, sub, and, or, xor, shift
// - Only PC and flags special; no stack
// - PC and flags duplicated; vector precharged
// - One incrementer shared by both PCs
// - No nesting; bank not saved
// - One-cycle entry pulse invalidates opcode before mode
// - Interrupt return jumps back to normal copy
// - Request still active on return chains handler
// - Thirty-eight instructions, one illegal encoding
// - Register arithmetic with carry and borrow forms
// - Bit 7 selects 4-bit unsigned immediate
// - Logic ops set N,Z only
// - Right shift/rotate by one, bit0 to carry
// - Memory load sets N,Z; write keeps flags
// - Byte immediate load, flags untouched
// - Visible PC is one past current
// - Branch condition from top four opcode bits
// - Indirect jump loads PC from second source
// - Reset clears PC, forces normal mode
package c16i_pkg;

  localparam int          C16I_DW        = 16;
  localparam int          C16I_NREG      = 8;
  localparam int          C16I_AW        = 12;
  localparam logic [11:0] C16I_CTRL_OFS   = 12'h000;
  localparam logic [11:0] C16I_STATUS_OFS = 12'h004;
  localparam int          C16I_CTRL_RUN  = 0;
  localparam int          C16I_STAT_MODE = 16;
  localparam int          C16I_STAT_RUN  = 17;

  localparam int          C16I_FLAG_C = 0;
  localparam int          C16I_FLAG_Z = 1;
  localparam int          C16I_FLAG_N = 2;
  localparam int          C16I_FLAG_V = 3;

  localparam logic [4:0]  C16I_OP_ADD          = 5'h00;
  localparam logic [4:0]  C16I_OP_ADD_CARRY    = 5'h01;
  localparam logic [4:0]  C16I_OP_SUB          = 5'h02;
  localparam logic [4:0]  C16I_OP_DIFF_BORROW  = 5'h03;
  localparam logic [4:0]  C16I_OP_COMPARE_ONLY = 5'h04;
  localparam logic [4:0]  C16I_OP_AND          = 5'h05;
  localparam logic [4:0]  C16I_OP_TEST_CONJ    = 5'h06;
  localparam logic [4:0]  C16I_OP_OR           = 5'h07;
  localparam logic [4:0]  C16I_OP_XOR          = 5'h08;
  localparam logic [4:0]  C16I_OP_INVERT       = 5'h09;
  localparam logic [4:0]  C16I_OP_SHIFT        = 5'h0a;
  localparam logic [4:0]  C16I_OP_ROTATE       = 5'h0b;
  localparam logic [4:0]  C16I_OP_MEMORY       = 5'h0c;
  localparam logic [4:0]  C16I_OP_JUMP_GROUP   = 5'h0d;
  localparam logic [4:0]  C16I_OP_INLINE_FETCH = 5'h0e;
  localparam logic [4:0]  C16I_OP_BYTE_IMM     = 5'h0f;

  localparam logic [2:0]  C16I_BR_ZERO     = 3'h0;
  localparam logic [2:0]  C16I_BR_NONZERO  = 3'h1;
  localparam logic [2:0]  C16I_BR_CARRY    = 3'h2;
  localparam logic [2:0]  C16I_BR_NOCARRY  = 3'h3;
  localparam logic [2:0]  C16I_BR_NEGATIVE = 3'h4;
  localparam logic [2:0]  C16I_BR_POSITIVE = 3'h5;
  localparam logic [2:0]  C16I_BR_OVERFLOW = 3'h6;
  localparam logic [2:0]  C16I_BR_ALWAYS   = 3'h7;

  typedef struct packed {
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [C16I_AW-1:0]  paddr;
    logic [31:0]         pwdata;
  } c16i_apb_req_t;

  typedef struct packed {
    logic [C16I_NREG-1:0][C16I_DW-1:0] bank;
    logic [1:0][C16I_DW-1:0]           pc;
    logic [1:0][3:0]                   flags;
    logic [C16I_DW-1:0]                instr_reg;
    logic                              instr_valid;
    logic                              mode;
    logic                              entry;
    logic                              illegal;
    logic [C16I_DW-1:0]                mem_addr;
    logic                              mem_we;
    logic [C16I_DW-1:0]                mem_wdata;
    logic                              run;
    logic                              pready;
    logic                              pslverr;
    logic [31:0]                       prdata;
  } c16i_state_t;

  // PC zero, normal mode, core running
  localparam c16i_state_t C16I_STATE_RST = '{run: 1'b1, default: '0};

endpackage

/* File: sim/c16i_mem_model.sv */
// Purpose: Program/data memory and interrupt request partner
// Assumes: Read follows mem_addr at once; write at the rising edge
// Notes:   Only 256 words kept, upper address bits ignored
`timescale 1ns/1ps
`default_nettype none
module c16i_mem_model
  import c16i_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic [C16I_DW-1:0] mem_addr,
  input  wire logic               mem_we,
  input  wire logic [C16I_DW-1:0] mem_wdata,
  output logic [C16I_DW-1:0]      mem_rdata,
  input  wire logic [6:0]         irq_src,
  output logic                    irq_req,
  output logic [C16I_DW-1:0]      irq_vector
);
  logic [C16I_DW-1:0] mem [256];
  assign mem_rdata = mem[mem_addr[7:0]];
  always @(posedge ref_clk) begin
    if (mem_we) begin
      mem[mem_addr[7:0]] <= mem_wdata;
    end
  end
  // Higher source number wins, so the loop runs upwards
  always_comb begin
    irq_req    = |irq_src;
    irq_vector = 16'h0000;
    for (int i = 0; i < 7; i++) begin
      if (irq_src[i]) begin
        irq_vector = 16'(4 * (i + 1));
      end
    end
  end
endmodule  // c16i_mem_model
`default_nettype wire

/* File: sim/tb.sv */
// Purpose: Self-checking bench for the dual-mode core
// Assumes: Program and handlers placed in the memory model before reset
// Notes:   Idle loop at the end gives interrupts a quiet place to land
`timescale 1ns/1ps
`default_nettype none
module tb;
  import c16i_pkg::*;
  logic          ref_clk = 1'b0;
  logic          reset_n = 1'b0;
  c16i_apb_req_t apb_req = '0;
  logic          pready, pslverr, mem_we, irq_req, entry, irq_mode, err, illegal;
  int            n_illegal = 0;
  logic [31:0]   prdata, q, rng;
  logic [15:0]   mem_addr, mem_wdata, mem_rdata, irq_vector, a, b;
  logic [6:0]    irq_src = '0;
  logic [4:0]    ops [6] = '{C16I_OP_ADD, C16I_OP_SUB, C16I_OP_AND, C16I_OP_OR, C16I_OP_XOR, C16I_OP_SHIFT};
  int            n_mismatch = 0;
  int            samples_checked = 0;
  int            p;
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (illegal === 1'b1) begin
      n_illegal++;
    end
  end
  c16i_core dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .apb_req(apb_req), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .mem_addr(mem_addr), .mem_we(mem_we), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .irq_req(irq_req), .irq_vector(irq_vector), .interrupt_entry_pulse(entry), .irq_mode(irq_mode),
    .illegal_op(illegal));
  c16i_mem_model mem_u (.ref_clk(ref_clk), .mem_addr(mem_addr), .mem_we(mem_we), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .irq_src(irq_src), .irq_req(irq_req), .irq_vector(irq_vector));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [15:0] alu(input logic [4:0] op, input logic [15:0] x, input logic [15:0] y);
    case (op)
      C16I_OP_ADD: return x + y;
      C16I_OP_SUB: return x - y;
      C16I_OP_AND: return x & y;
      C16I_OP_OR:  return x | y;
      C16I_OP_XOR: return x ^ y;
      default:     return {1'b0, y[15:1]};
    endcase
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Held until pready is seen high at a rising edge, never a fixed count
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge ref_clk);
    apb_req.psel <= 1'b1;
    apb_req.pwrite <= wr;
    apb_req.paddr <= ad;
    apb_req.pwdata <= wd;
    @(posedge ref_clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    q = prdata;
    err = pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    check(32'(k < 50), 32'h1);
  endtask
  // Sel 0 waits for an address, 1 for the entry pulse, 2 for normal mode
  task automatic wait_for(input int sel, input logic [15:0] ad);
    int k;
    k = 0;
    do begin
      @(negedge ref_clk);
      k++;
    end while (k < 500 && !((sel == 0 && mem_addr === ad) || (sel == 1 && entry === 1'b1)
               || (sel == 2 && irq_mode === 1'b0)));
    check(32'(k < 500), 32'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    rng = xs(32'h7365);
    a = {8'h00, rng[7:0]};
    rng = xs(rng);
    b = {8'h00, rng[7:0]};
    for (int i = 0; i < 256; i++) begin
      mem_u.mem[i] = 16'hffff;
    end
    mem_u.mem[0] = 16'h5880;
    mem_u.mem[1] = 16'hf03e;
    mem_u.mem[8] = 16'h7d11;
    mem_u.mem[9] = 16'h60f5;
    mem_u.mem[10] = 16'h6888;
    mem_u.mem[20] = 16'h7d5a;
    mem_u.mem[21] = 16'h60f5;
    mem_u.mem[22] = 16'h6888;
    mem_u.mem[64] = {8'h79, a[7:0]};
    mem_u.mem[65] = {8'h7a, b[7:0]};
    mem_u.mem[66] = 16'h7f80;
    p = 67;
    foreach (ops[i]) begin
      mem_u.mem[p] = {ops[i], 11'h312};
      mem_u.mem[p + 1] = 16'h60f3;
      mem_u.mem[p + 2] = 16'h07f1;
      p = p + 3;
    end
    mem_u.mem[p] = 16'h6c00;
    mem_u.mem[p + 1] = 16'h60f4;
    mem_u.mem[p + 2] = 16'h7800;
    mem_u.mem[p + 3] = 16'hfffe;
    repeat (12) @(posedge ref_clk);
    check({16'h0, mem_addr}, 32'h0);
    check({31'h0, irq_mode}, 32'h0);
    reset_n <= 1'b1;
    apb(1'b0, C16I_CTRL_OFS, 32'h0);
    check(q, 32'h0000_0001);
    apb(1'b0, 12'h008, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b1, C16I_CTRL_OFS, 32'h0);
    apb(1'b0, C16I_STATUS_OFS, 32'h0);
    check({30'h0, q[17:16]}, 32'h0);
    apb(1'b1, C16I_CTRL_OFS, 32'h1);
    wait_for(0, 16'(p + 3));
    foreach (ops[i]) begin
      check({16'h0, mem_u.mem[128 + i]}, {16'h0, alu(ops[i], a, b)});
    end
    check({16'h0, mem_u.mem[134]}, 32'(p + 1));
    @(posedge ref_clk);
    irq_src <= 7'h12;
    wait_for(1, 16'h0);
    @(negedge ref_clk);
    check({30'h0, irq_mode, entry}, 32'h2);
    check({16'h0, mem_addr}, 32'h0014);
    @(posedge ref_clk);
    irq_src <= 7'h02;
    wait_for(0, 16'h0008);
    check({31'h0, irq_mode}, 32'h1);
    @(posedge ref_clk);
    irq_src <= 7'h00;
    wait_for(2, 16'h0);
    check({16'h0, mem_u.mem[134]}, 32'h0011);
    wait_for(0, 16'(p + 3));
    check(32'(n_illegal), 32'h1);
    wrap_up();
  end
endmodule  // tb
`default_nettype wire
